// *** rtl/wakeup_frame_regs.svh ***
`ifndef WAKEUP_FRAME_REGS_SVH
`define WAKEUP_FRAME_REGS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PAT0_CRC_LOW_OFFS   9'h130
`define PAT0_CRC_HIGH_OFFS  9'h132
`define PAT0_SEL0_OFFS      9'h134
`define PAT0_SEL1_OFFS      9'h136
`define PAT0_SEL2_OFFS      9'h138
`define PAT0_SEL3_OFFS      9'h13a
`define PAT1_CRC_LOW_OFFS   9'h140
`define PAT1_CRC_HIGH_OFFS  9'h142
`define PAT1_SEL0_OFFS      9'h144
`define PAT1_SEL1_OFFS      9'h146
`define PAT1_SEL2_OFFS      9'h148
`define PAT1_SEL3_OFFS      9'h14a
`define PAT_REG_RESET       16'h0000

// ****************************************
// CRC constants
// ****************************************
`define CRC_POLY_REFL       32'hedb8_8320
`define CRC_INIT            32'hffff_ffff
`define MAX_FRAME_BYTES     7'd64

`endif

// *** rtl/wakeup_frame_pkg.sv ***
package wakeup_frame_pkg;

    typedef struct packed {
        logic [15:0] crc_low;
        logic [15:0] crc_high;
        logic [63:0] byte_select;
    } pattern_cfg_type;

    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic [7:0] data;
    } rx_byte_type;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FRAME = 3'b010,
        ST_DONE  = 3'b100
    } match_state_type;

endpackage

// *** rtl/pattern_crc_match.sv ***
`timescale 1ns/100ps
`include "wakeup_frame_regs.svh"

module pattern_crc_match
    import wakeup_frame_pkg::*;
(
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_n_i,
    input  wire wakeup_frame_pkg::pattern_cfg_type cfg_i,
    input  wire logic                        enable_i,
    input  wire wakeup_frame_pkg::rx_byte_type rx_i,
    output logic                             match_o
);
    import wakeup_frame_pkg::*;

    logic [31:0]     crc_q;
    logic [31:0]     crc_d;
    logic [6:0]      idx_q;
    logic [6:0]      idx_d;
    logic            match_q;
    logic            match_d;
    match_state_type state_q;
    match_state_type state_d;
    logic [31:0]     crc_step;
    logic [31:0]     crc_base;
    logic [6:0]      idx_base;
    logic            byte_on;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h00_0000, d};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ `CRC_POLY_REFL) : (r >> 1);
        end
        return r;
    endfunction

    always_comb
    begin
        crc_base = rx_i.sof ? `CRC_INIT : crc_q;
        idx_base = rx_i.sof ? 7'd0 : idx_q;
        // byte n maps to mask bit n-1
        byte_on  = (idx_base < `MAX_FRAME_BYTES) && cfg_i.byte_select[idx_base[5:0]];
        crc_step = crc_byte(crc_base, rx_i.data);
        crc_d    = crc_q;
        idx_d    = idx_q;
        match_d  = 1'b0;
        state_d  = state_q;
        case (state_q)
            ST_IDLE, ST_DONE:
            begin
                state_d = ST_IDLE;
                if (rx_i.valid && rx_i.sof)
                begin
                    state_d = ST_FRAME;
                end
            end
            ST_FRAME: ;
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
        if (rx_i.valid && (rx_i.sof || state_q == ST_FRAME))
        begin
            crc_d = byte_on ? crc_step : crc_base;
            idx_d = (idx_base < `MAX_FRAME_BYTES) ? idx_base + 7'd1 : idx_base;
            if (rx_i.eof)
            begin
                state_d = ST_DONE;
                match_d = enable_i &&
                          (~(byte_on ? crc_step : crc_base) == {cfg_i.crc_high, cfg_i.crc_low});
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            crc_q   <= `CRC_INIT;
            idx_q   <= 7'd0;
            match_q <= 1'b0;
            state_q <= ST_IDLE;
        end
        else
        begin
            crc_q   <= crc_d;
            idx_q   <= idx_d;
            match_q <= match_d;
            state_q <= state_d;
        end
    end

    assign match_o = match_q;

    chk_match_needs_enable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        match_q |-> $past(enable_i))
        else $error("match without enable");

    // match only after end of frame
    chk_match_after_eof: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        match_q |-> $past(rx_i.valid) && $past(rx_i.eof))
        else $error("match without frame end");

    chk_index_bound: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        idx_q <= `MAX_FRAME_BYTES)
        else $error("byte index past 64");

    chk_unmasked_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (rx_i.valid && !rx_i.sof && state_q == ST_FRAME && !byte_on) |=> crc_q == $past(crc_q))
        else $error("unmasked byte changed crc");

endmodule

// *** rtl/wakeup_frame_pattern_match.sv ***
`timescale 1ns/100ps
`include "wakeup_frame_regs.svh"

// Notes on behaviour
// - CRC low half per pattern register
// - CRC high half per pattern register
// - Ethernet CRC over masked bytes only
// - Mask word 0 selects bytes 1-16
// - Mask word 1 selects bytes 17-32
// - Mask word 2 selects bytes 33-48
// - Mask word 3 selects bytes 49-64
// - Second independent pattern set
// - Detection only while pattern enabled
module wakeup_frame_pattern_match
    import wakeup_frame_pkg::*;
(
    input  wire logic                          clk_sys_i,
    input  wire logic                          reset_n_i,
    input  wire logic [8:0]                    reg_addr_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    input  wire logic [15:0]                   reg_wdata_i,
    input  wire logic [1:0]                    reg_be_i,
    output logic [15:0]                        reg_rdata_o,
    output logic                               reg_rvalid_o,
    input  wire logic                          pattern0_detect_enable_i,
    input  wire logic                          pattern1_detect_enable_i,
    input  wire wakeup_frame_pkg::rx_byte_type rx_i,
    output logic                               pattern0_match_o,
    output logic                               pattern1_match_o
);
    import wakeup_frame_pkg::*;

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0]  rst_sync_q;
    logic        rst_n;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_sync_q <= 2'b00;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ****************************************
    // Register file
    // ****************************************
    logic [15:0] regs_q [12];
    logic [15:0] regs_d [12];
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic        rvalid_q;
    logic        rvalid_d;
    logic [3:0]  sel;
    logic        hit;

    always_comb
    begin
        hit = 1'b1;
        sel = 4'd0;
        case (reg_addr_i & 9'h1fe)
            `PAT0_CRC_LOW_OFFS:  sel = 4'd0;
            `PAT0_CRC_HIGH_OFFS: sel = 4'd1;
            `PAT0_SEL0_OFFS:     sel = 4'd2;
            `PAT0_SEL1_OFFS:     sel = 4'd3;
            `PAT0_SEL2_OFFS:     sel = 4'd4;
            `PAT0_SEL3_OFFS:     sel = 4'd5;
            `PAT1_CRC_LOW_OFFS:  sel = 4'd6;
            `PAT1_CRC_HIGH_OFFS: sel = 4'd7;
            `PAT1_SEL0_OFFS:     sel = 4'd8;
            `PAT1_SEL1_OFFS:     sel = 4'd9;
            `PAT1_SEL2_OFFS:     sel = 4'd10;
            `PAT1_SEL3_OFFS:     sel = 4'd11;
            default:             hit = 1'b0;
        endcase
    end

    always_comb
    begin
        regs_d   = regs_q;
        rvalid_d = reg_rd_i;
        // Unmapped and reserved addresses read as zero
        rdata_d  = reg_rd_i && hit ? regs_q[sel] : 16'h0000;
        if (reg_wr_i && hit)
        begin
            // byte-lane writes of CRC halves and masks
            if (reg_be_i[0])
            begin
                regs_d[sel][7:0] = reg_wdata_i[7:0];
            end
            if (reg_be_i[1])
            begin
                regs_d[sel][15:8] = reg_wdata_i[15:8];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 12; i++)
            begin
                regs_q[i] <= `PAT_REG_RESET;
            end
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end
        else
        begin
            regs_q   <= regs_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata_o  = rdata_q;
    assign reg_rvalid_o = rvalid_q;

    // ****************************************
    // Pattern engines
    // ****************************************
    pattern_cfg_type cfg0;
    pattern_cfg_type cfg1;

    // Bit n-1 of the joined mask words selects frame byte n
    // second set from its own registers
    always_comb
    begin
        cfg0.crc_low             = regs_q[0];
        cfg1.crc_low             = regs_q[6];
        cfg0.crc_high            = regs_q[1];
        cfg1.crc_high            = regs_q[7];
        cfg0.byte_select[15:0]   = regs_q[2];
        cfg1.byte_select[15:0]   = regs_q[8];
        cfg0.byte_select[31:16]  = regs_q[3];
        cfg1.byte_select[31:16]  = regs_q[9];
        cfg0.byte_select[47:32]  = regs_q[4];
        cfg1.byte_select[47:32]  = regs_q[10];
        cfg0.byte_select[63:48]  = regs_q[5];
        cfg1.byte_select[63:48]  = regs_q[11];
    end

    pattern_crc_match u_match0 (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n),
        .cfg_i     (cfg0),
        .enable_i  (pattern0_detect_enable_i),
        .rx_i      (rx_i),
        .match_o   (pattern0_match_o)
    );

    pattern_crc_match u_match1 (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n),
        .cfg_i     (cfg1),
        .enable_i  (pattern1_detect_enable_i),
        .rx_i      (rx_i),
        .match_o   (pattern1_match_o)
    );

    // write lands in low CRC register
    chk_crc_low_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (reg_wr_i && reg_be_i == 2'b11 && reg_addr_i == `PAT0_CRC_LOW_OFFS)
        |=> regs_q[0] == $past(reg_wdata_i))
        else $error("crc low write lost");

    // write lands in high CRC register
    chk_crc_high_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (reg_wr_i && reg_be_i == 2'b11 && reg_addr_i == `PAT1_CRC_HIGH_OFFS)
        |=> regs_q[7] == $past(reg_wdata_i))
        else $error("crc high write lost");

    // pattern 0 write leaves pattern 1 mask word 0 alone
    chk_sets_independent: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (reg_wr_i && reg_addr_i[8:4] == 5'h13) |=> regs_q[8] == $past(regs_q[8]))
        else $error("pattern sets coupled");

    chk_mask_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (reg_rd_i && !reg_wr_i && reg_addr_i == `PAT0_SEL1_OFFS) |=> reg_rdata_o == regs_q[3])
        else $error("mask readback wrong");

    // low lane write keeps high byte
    chk_lane_write_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (reg_wr_i && reg_be_i == 2'b01 && reg_addr_i == `PAT0_SEL0_OFFS)
        |=> regs_q[2] == {$past(regs_q[2][15:8]), $past(reg_wdata_i[7:0])})
        else $error("byte lane write wrong");

    chk_mask2_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (reg_wr_i && reg_be_i == 2'b11 && reg_addr_i == `PAT0_SEL2_OFFS)
        |=> regs_q[4] == $past(reg_wdata_i))
        else $error("third mask write lost");

    chk_mask3_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (reg_wr_i && reg_be_i == 2'b11 && reg_addr_i == `PAT1_SEL3_OFFS)
        |=> regs_q[11] == $past(reg_wdata_i))
        else $error("fourth mask write lost");

    // second set reads its own word
    chk_set1_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (reg_rd_i && !reg_wr_i && reg_addr_i == `PAT1_CRC_LOW_OFFS)
        |=> reg_rvalid_o && reg_rdata_o == regs_q[6])
        else $error("second set readback wrong");

endmodule

// *** test/rx_frame_source.sv ***
`timescale 1ns/100ps

// ****************************************
// Receive path model, one byte per valid cycle
// ****************************************
module rx_frame_source
(
    input  wire logic                     clk_sys_i,
    output wakeup_frame_pkg::rx_byte_type rx_o
);
    import wakeup_frame_pkg::*;

    logic [7:0] frame_bytes [0:71];

    initial rx_o = '0;

    // Between bytes the data line shows the inverse, never a stale copy
    task automatic send(input int len, input int gap);
        for (int i = 0; i < len; i++)
        begin
            rx_o = '{valid: 1'b1, sof: (i == 0), eof: (i == len - 1), data: frame_bytes[i]};
            @(posedge clk_sys_i);
            #1;
            // Back to back bytes go straight on: one assignment per time step
            if (gap > 0 || i == len - 1)
            begin
                rx_o = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~frame_bytes[i]};
            end
            repeat (gap)
            begin
                @(posedge clk_sys_i);
                #1;
            end
        end
    endtask
endmodule

// *** test/testbench.sv ***
`timescale 1ns/100ps
`include "wakeup_frame_regs.svh"

`define CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("ERROR %s expected %h seen %h", what, exp, got); \
        end \
    end

module testbench;
    import wakeup_frame_pkg::*;

    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [8:0]  reg_addr = '0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_wdata = '0;
    logic [1:0]  reg_be = '0;
    logic [15:0] reg_rdata;
    logic        reg_rvalid;
    logic        en0 = 1'b0;
    logic        en1 = 1'b0;
    rx_byte_type rx;
    logic        m0;
    logic        m1;
    logic        eof_seen_q = 1'b0;
    logic [15:0] rd_q [$];
    logic [1:0]  match_q [$];
    logic [15:0] exp_rd;
    logic [1:0]  exp_m;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          seed = 22;

    always #50 clk_sys = ~clk_sys;

    wakeup_frame_pattern_match DUT (
        .clk_sys_i(clk_sys), .reset_n_i(reset_n), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_be_i(reg_be), .reg_rdata_o(reg_rdata),
        .reg_rvalid_o(reg_rvalid), .pattern0_detect_enable_i(en0), .pattern1_detect_enable_i(en1),
        .rx_i(rx), .pattern0_match_o(m0), .pattern1_match_o(m1));

    rx_frame_source src (.clk_sys_i(clk_sys), .rx_o(rx));

    function automatic logic [8:0] addr_of(input int p, input int k);
        return 9'h130 + 9'(p * 16 + k * 2);
    endfunction

    // Reflected CRC, fed only the selected bytes
    function automatic logic [31:0] crc_of(input logic [63:0] sel);
        logic [31:0] c;
        c = `CRC_INIT;
        for (int i = 0; i < 64; i++)
            if (sel[i])
            begin
                c = c ^ {24'h00_0000, src.frame_bytes[i]};
                for (int k = 0; k < 8; k++)
                    c = c[0] ? ((c >> 1) ^ `CRC_POLY_REFL) : (c >> 1);
            end
        return ~c;
    endfunction

    // One idle edge before each access keeps strobes from being reassigned
    task automatic reg_write(input logic [8:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_be = be;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1 reg_wr = 1'b0;
    endtask

    task automatic reg_read(input logic [8:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        rd_q.push_back(e);
        @(posedge clk_sys);
        #1 reg_rd = 1'b0;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ****************************************
    // Result monitors
    // ****************************************
    always @(posedge clk_sys)
    begin
        if (reg_rvalid === 1'b1)
        begin
            exp_rd = rd_q.pop_front();
            `CHK("read data", exp_rd, reg_rdata)
        end
    end

    always @(posedge clk_sys)
    begin
        if (eof_seen_q)
        begin
            exp_m = match_q.pop_front();
            `CHK("match pair", exp_m, {m1, m0})
        end
        else if (reset_n)
            `CHK("idle match", 2'b00, {m1, m0})
        eof_seen_q <= rx.valid & rx.eof;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        logic [63:0] sel [0:1];
        logic [15:0] w [0:5];
        logic [31:0] crc;
        logic        bad;
        repeat (16) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        // Unmapped write must leave every word at its reset value
        reg_write(9'h13c, 16'hffff, 2'b11);
        for (int p = 0; p < 2; p++)
            for (int k = 0; k < 6; k++)
                reg_read(addr_of(p, k), `PAT_REG_RESET);
        reg_read(9'h13c, 16'h0000);
        reg_write(`PAT0_SEL0_OFFS, 16'hffff, 2'b11);
        reg_write(`PAT0_SEL0_OFFS, 16'h1234, 2'b01);
        reg_read(`PAT0_SEL0_OFFS, 16'hff34);
        reg_write(`PAT0_SEL0_OFFS, 16'h5678, 2'b10);
        reg_read(`PAT0_SEL0_OFFS, 16'h5634);
        $display("test registers done");
        for (int t = 0; t < 6; t++)
        begin
            for (int i = 0; i < 72; i++)
                src.frame_bytes[i] = 8'($random(seed));
            for (int p = 0; p < 2; p++)
            begin
                sel[p] = (t == 0) ? 64'h8000_0000_0000_0001 : {$random(seed), $random(seed)};
                bad = (t < 5) && (t[0] ^ p[0]);
                crc = crc_of(sel[p]) ^ {31'h0000_0000, bad};
                w = '{crc[15:0], crc[31:16], sel[p][15:0], sel[p][31:16], sel[p][47:32], sel[p][63:48]};
                for (int k = 0; k < 6; k++)
                    reg_write(addr_of(p, k), w[k], 2'b11);
                for (int k = 0; k < 6; k++)
                    reg_read(addr_of(p, k), w[k]);
            end
            en0 = (t != 2);
            en1 = (t != 3);
            // Pattern 0 carries a bad CRC on odd frames before frame 5, pattern 1 on even ones
            match_q.push_back({(t >= 5 || t[0]) && en1, (t >= 5 || !t[0]) && en0});
            src.send(64 + 6 * (t % 2), t % 2);
            $display("test frame %0d done", t);
        end
        // Mid-run reset must bring every pattern 1 word back to zero
        repeat (2) @(posedge clk_sys);
        #1 reset_n = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int k = 0; k < 6; k++)
            reg_read(addr_of(1, k), `PAT_REG_RESET);
        $display("test reset done");
        for (int i = 0; i < 20 && (rd_q.size() + match_q.size()) > 0; i++)
            @(posedge clk_sys);
        if (rd_q.size() + match_q.size() > 0)
            mismatches++;
        end_of_test();
    end
endmodule
